// ==== ccu_pkg.sv ====
// Package for the capture/compare unit: register map, field layout, modes and carriers
package ccu_pkg;
    // Register word offsets (byte addresses on the bus)
    localparam logic [3:0] OFF_CONTROL   = 4'h0;
    localparam logic [3:0] OFF_DATA_LOW  = 4'h4;
    localparam logic [3:0] OFF_DATA_HIGH = 4'h8;
    localparam logic [3:0] OFF_STATUS    = 4'hC;
    // Control field layout
    localparam int MODE_LSB = 0;
    localparam int DUTY_LSB = 4;
    localparam logic [7:0] CONTROL_MASK = 8'h3F;
    // Status field layout
    localparam int FLAG_BIT   = 0;
    localparam int IRQEN_BIT  = 1;
    localparam int PINLVL_BIT = 2;
    // Reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] DATA_RST    = 8'h00;
    // Mode codes
    localparam logic [3:0] MODE_OFF      = 4'h0;
    localparam logic [3:0] MODE_TOGGLE   = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_R4   = 4'h6;
    localparam logic [3:0] MODE_CAP_R16  = 4'h7;
    localparam logic [3:0] MODE_SET_HI   = 4'h8;
    localparam logic [3:0] MODE_SET_LO   = 4'h9;
    localparam logic [3:0] MODE_SOFT     = 4'hA;
    localparam logic [3:0] MODE_SPECIAL  = 4'hB;
    // Prescale counts
    localparam logic [3:0] PRESC_4  = 4'h3;
    localparam logic [3:0] PRESC_16 = 4'hF;

    // Unit operating class
    typedef enum logic [3:0] {
        CCU_CLS_OFF = 4'b0001,
        CCU_CLS_CAP = 4'b0010,
        CCU_CLS_CMP = 4'b0100,
        CCU_CLS_PWM = 4'b1000
    } ccu_class_t;

    // Bus request carrier
    typedef struct packed {
        logic       read;
        logic       write;
        logic [3:0] address;
        logic [7:0] writedata;
    } ccu_bus_req_t;

    // Pin carrier
    typedef struct packed {
        logic level;
        logic enable;
    } ccu_pin_t;
endpackage : ccu_pkg

// ==== ccu_edge_det.sv ====
// Pin synchroniser and edge detector
`timescale 1ns/1ps
module ccu_edge_det (
    // Clock and reset
    input  wire logic sys_clk_in,
    input  wire logic reset_n_in,
    // Raw pin level
    input  wire logic pin_in,
    // Edge pulses
    output logic      rise_out,
    output logic      fall_out
);
    // Synchroniser and history state
    typedef struct packed {
        logic meta;   // First stage, read only by the second
        logic sync;   // Second stage
        logic last;   // Previous synchronised level
        logic rise;
        logic fall;
    } ccu_ed_state_t;

    ccu_ed_state_t st_r;
    ccu_ed_state_t st_nxt;

    // Next state: edges come from the second stage only
    always_comb begin
        st_nxt      = st_r;
        st_nxt.meta = pin_in;
        st_nxt.sync = st_r.meta;
        st_nxt.last = st_r.sync;
        st_nxt.rise = st_r.sync & ~st_r.last;
        st_nxt.fall = ~st_r.sync & st_r.last;
    end

    // Register, synchronous reset
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rise_out = st_r.rise;
    assign fall_out = st_r.fall;

    // Rise pulses follow a synchronised low-to-high change
    rise_seen_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        rise_out |-> $past(st_r.sync) && !$past(st_r.last)) else $error("bad rise pulse");
endmodule : ccu_edge_det

// ==== ccu_prescaler.sv ====
// Capture edge prescaler counter
`timescale 1ns/1ps
module ccu_prescaler #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             reset_n_in,
    // Control
    input  wire logic             clear_in,   // Unit off or capture left
    input  wire logic             edge_in,    // Qualifying rising edge
    input  wire logic [WIDTH-1:0] limit_in,   // Terminal count
    // Result
    output logic                  hit_out     // Combinational, same cycle as edge
);
    // Count state
    typedef struct packed {
        logic [WIDTH-1:0] count;
    } ccu_ps_state_t;

    ccu_ps_state_t st_r;
    ccu_ps_state_t st_nxt;

    // Count is kept across prescale changes; clear, or an edge at the limit, resets it
    always_comb begin
        st_nxt = st_r;
        if (clear_in) begin
            st_nxt.count = '0;
        end else if (edge_in) begin
            if (st_r.count >= limit_in) begin
                st_nxt.count = '0;
            end else begin
                st_nxt.count = st_r.count + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Early hit possible when limit drops below count
    assign hit_out = edge_in && !clear_in && (st_r.count >= limit_in);

    cleared_zero_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        clear_in |=> st_r.count == '0) else $error("prescaler not cleared");
endmodule : ccu_prescaler

// ==== ccu_unit.sv ====
// Capture/compare unit top: Avalon-MM registers, capture, compare and PWM duty latch
//
// Summary of operation
// - Mode field; zero code turns unit off
// - Toggle mode inverts pin, flags on match
// - Capture falling, rising, 4th or 16th rise
// - Mode 1000 pin low, match drives high
// - Mode 1001 pin high, match drives low
// - Mode 1010 only flags, pin follows port
// - Special event flags and clears timer
// - Conversion starts only when converter enabled
// - PWM duty from data low and bits
// - Capture/compare use timer, PWM period timer
// - Capture copies timer into data pair
// - Capture flags; only software clears flag
// - New capture overwrites, no overrun indication
// - Prescaler cleared when off, leaving capture
// - Prescale change keeps count, early capture
// - Port writes on output pin capture
// - Compare every cycle, action plus flag
// - Zero control forces compare latch low
// - Asynchronous timer capture not supported
// - Period match reloads duty, sets pin unless duty zero
//
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module ccu_unit (
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        reset_n_in,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    // Timers
    input  wire logic [15:0] sixteen_bit_timer_in,
    input  wire logic [7:0]  eight_bit_period_timer_in,
    input  wire logic [7:0]  period_match_value_in,
    // Port and pin
    input  wire logic        port_latch_in,      // Ordinary port output latch
    input  wire logic        port_direction_bit_in, // Low means output
    input  wire logic        pin_level_in,       // Level seen on the shared port pin
    output logic             unit_shared_pin_out,
    output logic             unit_shared_pin_oe_out,
    // Events to the system
    input  wire logic        adc_enabled_in,
    output logic             timer_clear_out,
    output logic             adc_start_out,
    output logic             unit_event_flag_out,
    output logic             unit_event_irq_enable_out,
    output logic             pwm_period_reset_out
);
    // All unit state
    typedef struct packed {
        logic [7:0] control;
        logic [7:0] data_low;
        logic [7:0] data_high;
        logic [1:0] duty_latch;     // Buffered duty low bits
        logic       flag;
        logic       irq_en;
        logic       cmp_latch;      // Compare output latch
        logic       pin;
        logic       pin_oe;
        logic       tclr;
        logic       adc;
        logic       pwm_rst;
        logic       ack;            // Bus answer pending
        logic [31:0] rdata;
    } ccu_state_t;

    ccu_state_t st_r;
    ccu_state_t st_nxt;

    ccu_pkg::ccu_bus_req_t req;
    ccu_pkg::ccu_pin_t     pin_drv;
    logic                  rise;
    logic                  fall;
    logic                  ps_hit;
    logic [3:0]            mode;
    logic [3:0]            new_mode;
    logic                  mode_changed;
    logic                  cap_event;
    logic                  cmp_match;
    logic                  pwm_match;
    logic                  wr_ctl;
    logic                  ps_clear;
    logic [3:0]            ps_limit;
    logic                  do_write;
    logic                  do_read;
    ccu_pkg::ccu_class_t   cls;

    // Bus request bundle
    assign req.read      = avs_read_in;
    assign req.write     = avs_write_in;
    assign req.address   = avs_address_in;
    assign req.writedata = avs_writedata_in[7:0];

    assign mode = st_r.control[ccu_pkg::MODE_LSB +: 4];

    // Class decode of a mode code
    function automatic ccu_pkg::ccu_class_t ccu_classify(input logic [3:0] m);
        ccu_pkg::ccu_class_t c;
        c = ccu_pkg::CCU_CLS_OFF;
        if (m[3:2] == 2'b11) begin
            c = ccu_pkg::CCU_CLS_PWM;
        end else if (m[3:2] == 2'b01) begin
            c = ccu_pkg::CCU_CLS_CAP;
        end else if (m[3] || m == ccu_pkg::MODE_TOGGLE) begin
            c = ccu_pkg::CCU_CLS_CMP;
        end
        return c;
    endfunction : ccu_classify

    assign cls = ccu_classify(mode);

    // Writes take effect at the edge where waitrequest is low
    assign do_write = req.write && st_r.ack;
    // Read data load as waitrequest falls, so they stand at the accepting edge
    assign do_read  = req.read && !st_r.ack;
    assign wr_ctl   = do_write && (req.address == ccu_pkg::OFF_CONTROL);
    assign new_mode = req.writedata[ccu_pkg::MODE_LSB +: 4];
    assign mode_changed = wr_ctl && (new_mode != mode);

    // Prescaler is cleared when the unit leaves capture or is off
    assign ps_clear = (cls != ccu_pkg::CCU_CLS_CAP) ||
                      (wr_ctl && ccu_classify(new_mode) != ccu_pkg::CCU_CLS_CAP);
    assign ps_limit = (mode == ccu_pkg::MODE_CAP_R16) ? ccu_pkg::PRESC_16 : ccu_pkg::PRESC_4;

    // Pin edges come through the synchroniser; port writes reach the pin too
    ccu_edge_det u_edge (
        .sys_clk_in (sys_clk_in),
        .reset_n_in (reset_n_in),
        .pin_in     (pin_level_in),
        .rise_out   (rise),
        .fall_out   (fall)
    );

    ccu_prescaler #(.WIDTH(4)) u_presc (
        .sys_clk_in (sys_clk_in),
        .reset_n_in (reset_n_in),
        .clear_in   (ps_clear),
        .edge_in    (rise && (mode == ccu_pkg::MODE_CAP_R4 || mode == ccu_pkg::MODE_CAP_R16)),
        .limit_in   (ps_limit),
        .hit_out    (ps_hit)
    );

    // Capture event selection
    always_comb begin
        case (mode)
            ccu_pkg::MODE_CAP_FALL: cap_event = fall;
            ccu_pkg::MODE_CAP_RISE: cap_event = rise;
            ccu_pkg::MODE_CAP_R4:   cap_event = ps_hit;
            ccu_pkg::MODE_CAP_R16:  cap_event = ps_hit;
            default:                cap_event = 1'b0;
        endcase
    end

    // Compare against the sixteen-bit timer every cycle
    assign cmp_match = (cls == ccu_pkg::CCU_CLS_CMP) &&
                       ({st_r.data_high, st_r.data_low} == sixteen_bit_timer_in);
    // PWM period match against the period timer
    assign pwm_match = (cls == ccu_pkg::CCU_CLS_PWM) &&
                       (eight_bit_period_timer_in == period_match_value_in);

    // Main next-state process
    always_comb begin
        st_nxt         = st_r;
        st_nxt.tclr    = 1'b0;
        st_nxt.adc     = 1'b0;
        st_nxt.pwm_rst = 1'b0;
        // One wait cycle per access, then answer
        st_nxt.ack     = (req.read || req.write) && !st_r.ack;

        // Read mux; unmapped reads zero
        if (do_read) begin
            case (req.address)
                ccu_pkg::OFF_CONTROL:   st_nxt.rdata = {24'h0000_00, st_r.control};
                ccu_pkg::OFF_DATA_LOW:  st_nxt.rdata = {24'h0000_00, st_r.data_low};
                ccu_pkg::OFF_DATA_HIGH: st_nxt.rdata = {24'h0000_00, st_r.data_high};
                ccu_pkg::OFF_STATUS:    st_nxt.rdata = {29'h0000_0000, st_r.pin,
                                                        st_r.irq_en, st_r.flag};
                default:                st_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // Register writes
        if (do_write) begin
            case (req.address)
                ccu_pkg::OFF_CONTROL: begin
                    st_nxt.control = req.writedata & ccu_pkg::CONTROL_MASK;
                end
                ccu_pkg::OFF_DATA_LOW: begin
                    st_nxt.data_low = req.writedata;
                end
                ccu_pkg::OFF_DATA_HIGH: begin
                    // High byte is read-only while in PWM
                    if (cls != ccu_pkg::CCU_CLS_PWM) begin
                        st_nxt.data_high = req.writedata;
                    end
                end
                ccu_pkg::OFF_STATUS: begin
                    // Software clears the flag by writing zero
                    st_nxt.flag   = req.writedata[ccu_pkg::FLAG_BIT];
                    st_nxt.irq_en = req.writedata[ccu_pkg::IRQEN_BIT];
                end
                default: begin
                    // Unmapped writes ignored
                end
            endcase
        end

        // Mode entry actions and off state
        if (wr_ctl) begin
            if (req.writedata == 8'h00) begin
                st_nxt.cmp_latch = 1'b0;
            end
            if (mode_changed && new_mode == ccu_pkg::MODE_SET_HI) begin
                st_nxt.cmp_latch = 1'b0;
            end
            if (mode_changed && new_mode == ccu_pkg::MODE_SET_LO) begin
                st_nxt.cmp_latch = 1'b1;
            end
        end

        // Capture: copy timer, overwrite silently, flag
        if (cap_event) begin
            st_nxt.data_low  = sixteen_bit_timer_in[7:0];
            st_nxt.data_high = sixteen_bit_timer_in[15:8];
            st_nxt.flag      = 1'b1;
        end

        // Compare actions; flag set wins over a software clear
        if (cmp_match) begin
            st_nxt.flag = 1'b1;
            case (mode)
                ccu_pkg::MODE_TOGGLE:  st_nxt.cmp_latch = ~st_r.cmp_latch;
                ccu_pkg::MODE_SET_HI:  st_nxt.cmp_latch = 1'b1;
                ccu_pkg::MODE_SET_LO:  st_nxt.cmp_latch = 1'b0;
                ccu_pkg::MODE_SOFT:    st_nxt.cmp_latch = st_r.cmp_latch;
                ccu_pkg::MODE_SPECIAL: begin
                    st_nxt.tclr = 1'b1;
                    st_nxt.adc  = adc_enabled_in;
                end
                default: begin
                    // Not a compare code
                end
            endcase
        end

        // PWM period end: reload duty, set pin unless duty zero
        if (pwm_match) begin
            st_nxt.pwm_rst    = 1'b1;
            st_nxt.data_high  = st_r.data_low;
            st_nxt.duty_latch = st_r.control[ccu_pkg::DUTY_LSB +: 2];
            st_nxt.cmp_latch  = ({st_r.data_low, st_r.control[ccu_pkg::DUTY_LSB +: 2]}
                                 != 10'h000);
        end

        // Off state clears the compare latch and the duty latch
        if (cls == ccu_pkg::CCU_CLS_OFF && !wr_ctl) begin
            st_nxt.cmp_latch  = 1'b0;
            st_nxt.duty_latch = 2'b00;
        end

        // Pin driver selection
        pin_drv.enable = ~port_direction_bit_in;
        case (cls)
            ccu_pkg::CCU_CLS_CMP: begin
                if (mode == ccu_pkg::MODE_SOFT || mode == ccu_pkg::MODE_SPECIAL) begin
                    pin_drv.level = port_latch_in;
                end else begin
                    pin_drv.level = st_nxt.cmp_latch;
                end
            end
            ccu_pkg::CCU_CLS_PWM: pin_drv.level = st_nxt.cmp_latch;
            default:              pin_drv.level = port_latch_in;
        endcase
        st_nxt.pin    = pin_drv.level;
        st_nxt.pin_oe = pin_drv.enable;
    end

    // State register
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            st_r         <= '0;
            st_r.control <= ccu_pkg::CONTROL_RST;
            st_r.data_low  <= ccu_pkg::DATA_RST;
            st_r.data_high <= ccu_pkg::DATA_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign avs_readdata_out         = st_r.rdata;
    assign avs_waitrequest_out      = ~st_r.ack;
    assign unit_shared_pin_out      = st_r.pin;
    assign unit_shared_pin_oe_out   = st_r.pin_oe;
    assign timer_clear_out          = st_r.tclr;
    assign adc_start_out            = st_r.adc;
    assign unit_event_flag_out      = st_r.flag;
    assign unit_event_irq_enable_out = st_r.irq_en;
    assign pwm_period_reset_out     = st_r.pwm_rst;

    // Capture copies the timer of the event cycle
    capture_copy_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        cap_event |=> {st_r.data_high, st_r.data_low} == $past(sixteen_bit_timer_in))
        else $error("capture value wrong");
    // Capture raises the flag
    capture_flag_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        cap_event |=> st_r.flag) else $error("capture flag missing");
    // Flag never falls without a status write
    flag_sticky_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        $fell(st_r.flag) |-> $past(do_write && req.address == ccu_pkg::OFF_STATUS))
        else $error("flag cleared by hardware");
    // Toggle mode inverts the latch
    toggle_match_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        cmp_match && mode == ccu_pkg::MODE_TOGGLE && !wr_ctl |=>
        st_r.cmp_latch != $past(st_r.cmp_latch)) else $error("toggle failed");
    // Set-high match drives the latch high
    set_high_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        cmp_match && mode == ccu_pkg::MODE_SET_HI && !wr_ctl |=> st_r.cmp_latch)
        else $error("set high failed");
    // Set-low match drives the latch low
    set_low_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        cmp_match && mode == ccu_pkg::MODE_SET_LO && !wr_ctl |=> !st_r.cmp_latch)
        else $error("set low failed");
    // Special event clears the timer and gates the converter
    special_event_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        cmp_match && mode == ccu_pkg::MODE_SPECIAL |=>
        timer_clear_out && (adc_start_out == $past(adc_enabled_in)))
        else $error("special event wrong");
    // No conversion without an enabled converter
    adc_gate_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        adc_start_out |-> $past(adc_enabled_in)) else $error("adc start ungated");
    // Zero control write forces the latch low
    zero_ctl_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        wr_ctl && req.writedata == 8'h00 |=> !st_r.cmp_latch)
        else $error("latch not forced low");
    // PWM period end loads the duty
    pwm_reload_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        pwm_match && !do_write |=> st_r.data_high == $past(st_r.data_low) && pwm_period_reset_out)
        else $error("duty not reloaded");
endmodule : ccu_unit

// ==== ccu_pin_model.sv ====
// Far-side model of the shared pin: a signal source that yields while the unit drives
`timescale 1ns/1ps
module ccu_pin_model (
    // Pin as driven by the unit
    input  wire logic pin_drive_in,
    input  wire logic pin_oe_in,
    // Source level while the pin is an input
    input  wire logic src_level_in,
    // Level seen on the wire
    output logic      pin_level_out
);
    // Driven level wins, so port writes on an output pin come back as edges
    assign pin_level_out = pin_oe_in ? pin_drive_in : src_level_in;
endmodule : ccu_pin_model

// ==== capture_compare_pwm_unit_bench.sv ====
// Self-checking bench for the capture/compare unit
`timescale 1ns/1ps
module capture_compare_pwm_unit_bench;
    // Clock, reset and bus
    logic        sys_clk_in, reset_n_in, rd, wr, wait_rq;
    logic [3:0]  adr;
    logic [31:0] wdat, rdat;
    // Timers, port and events
    logic [15:0] timer, seed, cmp;
    logic [7:0]  ptmr, pmatch;
    logic        tinc, latch, dir, src, pin_lvl, pin, oe, adc_en, tclr, adc_go, flag, irq, prst;
    // Scoreboard
    int          miscompares, check_count;
    logic [31:0] rd_q[$];
    logic        adc_q[$];
    // Mode tables: capture kinds, compare kinds with pin before and after match
    logic [3:0]  cap_m[4] = '{4'h4, 4'h5, 4'h6, 4'h7};
    int          cap_n[4] = '{1, 1, 4, 16};
    logic [3:0]  cmp_m[6] = '{4'h8, 4'h9, 4'h2, 4'hA, 4'hB, 4'hB};
    logic        pin0[6] = '{0, 1, 0, 1, 1, 1};
    logic        pin1[6] = '{1, 0, 1, 1, 1, 1};
    logic        lat[6] = '{0, 0, 0, 1, 1, 1};
    logic        adc[6] = '{0, 0, 0, 0, 1, 0};

    ccu_unit DUT (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wait_rq),
        .sixteen_bit_timer_in(timer), .eight_bit_period_timer_in(ptmr),
        .period_match_value_in(pmatch), .port_latch_in(latch), .port_direction_bit_in(dir),
        .pin_level_in(pin_lvl), .unit_shared_pin_out(pin), .unit_shared_pin_oe_out(oe),
        .adc_enabled_in(adc_en), .timer_clear_out(tclr), .adc_start_out(adc_go),
        .unit_event_flag_out(flag), .unit_event_irq_enable_out(irq),
        .pwm_period_reset_out(prst));
    ccu_pin_model PIN (.pin_drive_in(pin), .pin_oe_in(oe), .src_level_in(src),
        .pin_level_out(pin_lvl));

    // Free-running clock, 40 ns period
    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end
    // Timer counts on the system clock only, never asynchronously
    always @(posedge sys_clk_in) begin
        if (tinc) timer <= tclr ? 16'h0000 : timer + 16'h0001;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // Two kinds of comparison: bus words and single levels
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word
    task automatic check_bit(input logic got, input logic exp);
        check_word({31'h0, got}, {31'h0, exp});
    endtask : check_bit
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask : tick
    // One bus cycle: held until waitrequest is sampled low, then released
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= {24'h0000_00, d};
        do begin
            @(posedge sys_clk_in);
        end while (wait_rq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    // Read note goes on the queue before the request
    task automatic rd_exp(input logic [3:0] a, input logic [7:0] e);
        rd_q.push_back({24'h0000_00, e});
        bus(1'b0, a, 8'h00);
    endtask : rd_exp
    // Pin pulse from the far-side source, long enough for the synchroniser
    task automatic pulse();
        src <= 1'b1;
        tick(6);
        src <= 1'b0;
        tick(6);
    endtask : pulse
    // Read data settle at the acknowledging edge; compare against the oldest note
    always @(posedge sys_clk_in) begin
        if (rd && wait_rq === 1'b0) begin
            if (rd_q.size() == 0) miscompares++;
            else check_word(rdat, rd_q.pop_front());
        end
    end
    // Each special event pulse carries a conversion start only if the converter is on
    always @(posedge sys_clk_in) begin
        if (tclr === 1'b1) begin
            if (adc_q.size() == 0) miscompares++;
            else check_bit(adc_go, adc_q.pop_front());
        end
    end
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    // Watchdog well beyond the expected thousand or so cycles
    initial begin
        #1200000;
        miscompares++;
        print_verdict();
    end

    // Main sequence
    initial begin
        {rd, wr, adr, wdat, tinc, latch, src, adc_en, ptmr} = '0;
        {timer, dir, pmatch, seed} = {16'h0000, 1'b1, 8'hFF, 16'h8FBC};
        reset_n_in = 1'b0;
        tick(4);
        reset_n_in <= 1'b1;
        rd_exp(ccu_pkg::OFF_CONTROL, 8'h00);
        rd_exp(ccu_pkg::OFF_DATA_LOW, 8'h00);
        rd_exp(ccu_pkg::OFF_STATUS, 8'h00);
        bus(1'b1, 4'h2, 8'hFF);
        rd_exp(4'h2, 8'h00);
        bus(1'b1, ccu_pkg::OFF_CONTROL, 8'hFF);
        rd_exp(ccu_pkg::OFF_CONTROL, 8'h3F);
        bus(1'b1, ccu_pkg::OFF_STATUS, 8'h02);
        tick(1);
        check_bit(irq, 1'b1);
        $display("Test registers done");
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, ccu_pkg::OFF_CONTROL, 8'h00);
            bus(1'b1, ccu_pkg::OFF_STATUS, 8'h00);
            bus(1'b1, ccu_pkg::OFF_CONTROL, {4'h0, cap_m[i]});
            repeat (cap_n[i] - 1) pulse();
            check_bit(flag, 1'b0);
            seed = lfsr(seed);
            timer <= seed;
            pulse();
            check_bit(flag, 1'b1);
            rd_exp(ccu_pkg::OFF_DATA_LOW, seed[7:0]);
            rd_exp(ccu_pkg::OFF_DATA_HIGH, seed[15:8]);
            timer <= ~seed;
            repeat (cap_n[i]) pulse();
            rd_exp(ccu_pkg::OFF_DATA_HIGH, ~seed[15:8]);
            check_bit(flag, 1'b1);
        end
        bus(1'b1, ccu_pkg::OFF_CONTROL, 8'h00);
        bus(1'b1, ccu_pkg::OFF_STATUS, 8'h00);
        tick(1);
        check_bit(flag, 1'b0);
        bus(1'b1, ccu_pkg::OFF_CONTROL, 8'h05);
        dir <= 1'b0;
        tick(6);
        latch <= 1'b1;
        tick(10);
        check_bit(flag, 1'b1);
        $display("Test capture done");
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            cmp = {2'b10, seed[13:0]};
            timer <= 16'h0000;
            latch <= 1'b0;
            bus(1'b1, ccu_pkg::OFF_CONTROL, 8'h00);
            bus(1'b1, ccu_pkg::OFF_STATUS, 8'h00);
            check_bit(pin, 1'b0);
            latch <= lat[i];
            adc_en <= adc[i];
            bus(1'b1, ccu_pkg::OFF_DATA_LOW, cmp[7:0]);
            bus(1'b1, ccu_pkg::OFF_DATA_HIGH, cmp[15:8]);
            bus(1'b1, ccu_pkg::OFF_CONTROL, {4'h0, cmp_m[i]});
            tick(3);
            check_bit(pin, pin0[i]);
            check_bit(oe, 1'b1);
            if (cmp_m[i] == ccu_pkg::MODE_SPECIAL) adc_q.push_back(adc[i]);
            timer <= cmp - 16'h0014;
            tinc <= 1'b1;
            tick(40);
            tinc <= 1'b0;
            check_bit(pin, pin1[i]);
            check_bit(flag, 1'b1);
            check_bit(timer[15], cmp_m[i] != ccu_pkg::MODE_SPECIAL);
        end
        check_word(adc_q.size(), 32'h0000_0000);
        $display("Test compare done");
        seed = lfsr(seed);
        bus(1'b1, ccu_pkg::OFF_CONTROL, 8'h2C);
        bus(1'b1, ccu_pkg::OFF_DATA_LOW, seed[7:0]);
        bus(1'b1, ccu_pkg::OFF_DATA_HIGH, ~seed[7:0]);
        rd_exp(ccu_pkg::OFF_DATA_HIGH, cmp[15:8]);
        pmatch <= seed[15:8];
        ptmr <= seed[15:8];
        tick(1);
        ptmr <= ~seed[15:8];
        tick(1);
        check_bit(prst, 1'b1);
        tick(3);
        rd_exp(ccu_pkg::OFF_DATA_HIGH, seed[7:0]);
        rd_exp(ccu_pkg::OFF_CONTROL, 8'h2C);
        check_bit(pin, 1'b1);
        $display("Test duty latch done");
        print_verdict();
    end
endmodule : capture_compare_pwm_unit_bench
